//--- verification/fan_span_config_test.sv
// Self-checking bench for the three fan-drive span/rate registers.
// Assumes fan_span_pkg is compiled first and the header is on the path.
`timescale 1ns/100ps
`default_nettype none
`include "fan_span_params.svh"
module fan_span_config_test;
  import fan_span_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic lock_out;
  fan_drive_channel_t [2:0] chan_out;
  logic [2:0] high_band_out;
  logic [8:0] low_rate_out;
  logic [7:0] e [3];
  logic lk = 1'b0;
  // Rows 0..7 walk every rate code in low band, all rows every span code.
  logic [7:0] rows [16] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
    8'h66, 8'h77, 8'h88, 8'h99, 8'haa, 8'hbb, 8'hcc, 8'hdd, 8'hee, 8'hff};
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  always #2 clock_in = ~clock_in;
  fan_span_config dut (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .lock_out(lock_out),
    .fan_drive_channel_out(chan_out), .high_band_out(high_band_out),
    .low_rate_out(low_rate_out));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [23:0] x,
                     input logic [23:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // A write leaves its strobe high so writes follow with no gap; the
  // next read or output check lowers it, each signal set once per step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    addr_in <= a;
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk("rdata", {16'h0, x}, {16'h0, rdata_out});
    @(posedge clock_in);
  endtask : rd
  task automatic outs();
    logic [8:0] lr;
    logic [2:0] hb;
    wr_in <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      hb[c] = e[c][3];
      lr[c*3+:3] = e[c][3] ? 3'h0 : e[c][2:0];
    end
    @(posedge clock_in);
    @(negedge clock_in);
    chk("channels", {e[2], e[1], e[0]}, chan_out);
    chk("band", 24'(hb), 24'(high_band_out));
    chk("rate", 24'(lr), 24'(low_rate_out));
    chk("lock", 24'(lk), 24'(lock_out));
    chk("rdata idle", 24'h0, 24'(rdata_out));
    @(posedge clock_in);
  endtask : outs
  task automatic reset_check();
    e = '{`CHAN_RESET, `CHAN_RESET, `CHAN_RESET};
    lk = 1'b0;
    outs();
    for (int c = 0; c < 3; c++)
      rd(`OFF_CHAN0 + 8'(c), `CHAN_RESET);
  endtask : reset_check
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    reset_check();
    $display("power-on defaults done");
    for (int i = 0; i < 16; i++) begin
      e[i % 3] = rows[i];
      wr(`OFF_CHAN0 + 8'(i % 3), rows[i]);
      rd(`OFF_CHAN0 + 8'(i % 3), rows[i]);
      outs();
    end
    $display("row table done");
    rd(8'h10, `UNMAPPED_READ);
    wr(8'h62, 8'h5a);
    outs();
    // The lock is sticky, so writing zero must not reopen the channels.
    lk = 1'b1;
    wr(`OFF_LOCK, 8'h01);
    rd(`OFF_LOCK, 8'h01);
    for (int c = 0; c < 3; c++)
      wr(`OFF_CHAN0 + 8'(c), 8'h37);
    wr(`OFF_LOCK, 8'h00);
    wr(8'h60, 8'h12);
    outs();
    for (int c = 0; c < 3; c++)
      rd(`OFF_CHAN0 + 8'(c), e[c]);
    $display("lock test done");
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    reset_check();
    e[2] = 8'h08;
    wr(8'h61, 8'h08);
    outs();
    $display("second reset done");
    results();
  end
endmodule : fan_span_config_test
`default_nettype wire

//--- verilog/fan_span_config.sv
// Three fan-drive channel span/rate registers with a global write lock.
// Assumes a synchronous register port on clock_in with read data one
// cycle after the read strobe.
//
// Function
// - Rate field bits 2:0 pick 11.0..88.2 Hz in low band only.
// - Rate field resets to code 100, which is 35.3 Hz.
// - Bit 3 picks band: 1 high frequency, 0 low frequency.
// - Span field bits 7:4 pick 2..80 degrees C sweep span.
// - Span field resets to code 1100, which is 32 degrees C.
// - While lock bit is 1, channel register writes are ignored.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "fan_span_params.svh"

module fan_span_config
  import fan_span_pkg::*;
#(
  parameter int CHAN_N = `CHAN_N
) (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  input  wire logic [`ADDR_W-1:0]       addr_in,
  input  wire logic [`DATA_W-1:0]       wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [`DATA_W-1:0]       rdata_out,
  output logic                          lock_out,
  output fan_drive_channel_t [CHAN_N-1:0] fan_drive_channel_out,
  output logic      [CHAN_N-1:0]        high_band_out,
  output logic      [CHAN_N*3-1:0]      low_rate_out
);

  localparam logic [`ADDR_W-1:0] CHAN_OFF [3] =
    '{`OFF_CHAN0, `OFF_CHAN1, `OFF_CHAN2};

  ////////////////////////////////////////////////////////////////////////
  // Decode.

  logic [`DATA_W-1:0] chan_reg [CHAN_N];
  logic               lock_reg;
  logic [CHAN_N-1:0]  chan_hit;
  logic [`DATA_W-1:0] chan_rd [CHAN_N+1];
  logic [`DATA_W-1:0] rdata_next;
  wire                lock_hit;

  assign lock_hit = (addr_in == `OFF_LOCK);

  assign chan_rd[0] = lock_hit ?
    {{(`DATA_W-1){1'b0}}, lock_reg} : `UNMAPPED_READ;

  genvar gi;
  generate
    for (gi = 0; gi < CHAN_N; gi = gi + 1) begin : g_chan
      assign chan_hit[gi] = (addr_in == CHAN_OFF[gi]);
      assign chan_rd[gi+1] = chan_hit[gi] ? chan_reg[gi] : chan_rd[gi];

      // Writes are dropped while locked; the lock never unlocks the
      // channels early because it is sampled in the same cycle.
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          chan_reg[gi] <= `CHAN_RESET;
        end else if (wr_in && chan_hit[gi] && !lock_reg) begin
          chan_reg[gi] <= wdata_in;
        end
      end

      // Outputs are registered copies so each comes from a flip-flop.
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          fan_drive_channel_out[gi] <= fan_drive_channel_t'(`CHAN_RESET);
          high_band_out[gi]         <= `BAND_RESET;
          low_rate_out[gi*3 +: 3]   <= `RATE_RESET;
        end else begin
          fan_drive_channel_out[gi].pulse_rate_select <=
            pulse_rate_select_t'(chan_reg[gi][`RATE_MSB:`RATE_LSB]);
          fan_drive_channel_out[gi].drive_band_select <=
            chan_reg[gi][`BAND_BIT];
          fan_drive_channel_out[gi].temp_span <=
            chan_reg[gi][`SPAN_MSB:`SPAN_LSB];
          high_band_out[gi] <= chan_reg[gi][`BAND_BIT];
          // The rate only matters in low band, so high band reads zero.
          low_rate_out[gi*3 +: 3] <= chan_reg[gi][`BAND_BIT] ?
            3'h0 : chan_reg[gi][`RATE_MSB:`RATE_LSB];
        end
      end

      // Each copy is checked on its own, so a wiring slip between
      // channels shows up as a failure in that channel only.
      chan_open_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (wr_in && chan_hit[gi] && !lock_reg) |=>
          chan_reg[gi] == $past(wdata_in))
        else $error("open channel register missed its write");

      chan_locked_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (wr_in && chan_hit[gi] && lock_reg) |=> $stable(chan_reg[gi]))
        else $error("locked channel register took a write");

      // A write to any other address must leave this copy alone.
      chan_alone_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !(wr_in && chan_hit[gi]) |=> $stable(chan_reg[gi]))
        else $error("channel register changed without its own write");

      chan_band_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        1'b1 |=> high_band_out[gi] == $past(chan_reg[gi][`BAND_BIT]))
        else $error("band output does not follow its register");

      chan_low_rate_a: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !chan_reg[gi][`BAND_BIT] |=>
          low_rate_out[gi*3 +: 3] == $past(chan_reg[gi][`RATE_MSB:`RATE_LSB]))
        else $error("low band output does not show the rate field");
    end
  endgenerate

  // Unmapped addresses read as zero, so a stray strobe leaks no state.
  assign rdata_next = rd_in ? chan_rd[CHAN_N] : `UNMAPPED_READ;

  ////////////////////////////////////////////////////////////////////////
  // Lock and read data.

  // The lock is sticky until reset, so software cannot undo it.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lock_reg <= 1'b0;
    end else if (wr_in && lock_hit && wdata_in[`LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= `UNMAPPED_READ;
      lock_out  <= 1'b0;
    end else begin
      rdata_out <= rdata_next;
      lock_out  <= lock_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  // The generate loop carries the per-channel checks; those below watch
  // the shared lock, a few fixed channel taps and the read port.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  locked_write_a: assert property (
    (wr_in && chan_hit[0] && lock_reg) |=> $stable(chan_reg[0]))
    else $error("locked channel register changed on write");

  open_write_a: assert property (
    (wr_in && chan_hit[1] && !lock_reg) |=> chan_reg[1] == $past(wdata_in))
    else $error("unlocked write not stored");

  band_out_a: assert property (
    (wr_in && chan_hit[2] && !lock_reg) |=> ##1
      high_band_out[2] == $past(wdata_in[`BAND_BIT], 2))
    else $error("band output does not follow write");

  rate_out_a: assert property (
    high_band_out[0] |-> low_rate_out[2:0] == 3'h0)
    else $error("rate shown while in high band");

  span_out_a: assert property (
    ##1 fan_drive_channel_out[1].temp_span ==
      $past(chan_reg[1][`SPAN_MSB:`SPAN_LSB]))
    else $error("span output mismatch");

  rate_reset_a: assert property (
    $fell(rst_in) |-> !high_band_out[2] &&
      fan_drive_channel_out[2].pulse_rate_select == `RATE_RESET)
    else $error("rate output not at its reset code");

  span_reset_a: assert property (
    $fell(rst_in) |-> chan_reg[0][`SPAN_MSB:`SPAN_LSB] == `SPAN_RESET)
    else $error("span reset value wrong");

  span_out_reset_a: assert property (
    $fell(rst_in) |->
      fan_drive_channel_out[0].temp_span == `SPAN_RESET)
    else $error("span output not at its reset code");

  read_back_a: assert property (
    (rd_in && chan_hit[2]) |=> rdata_out == $past(chan_reg[2]))
    else $error("read data mismatch");

  lock_sticky_a: assert property (lock_reg |=> lock_reg)
    else $error("lock cleared without reset");

  lock_hold_a: assert property (
    (wr_in && lock_hit && !wdata_in[`LOCK_BIT]) |=>
      lock_reg == $past(lock_reg))
    else $error("writing zero changed the lock");

  // Software sees the lock through the read port and through lock_out;
  // both must agree with the one sticky flop behind them.
  lock_out_a: assert property (
    1'b1 |=> lock_out == $past(lock_reg))
    else $error("lock output does not follow the lock register");

  lock_read_a: assert property (
    (rd_in && lock_hit) |=>
      rdata_out == {{(`DATA_W-1){1'b0}}, $past(lock_reg)})
    else $error("lock read data mismatch");

  // A zero between reads keeps an old value from being taken twice.
  idle_read_a: assert property (
    !rd_in |=> rdata_out == `UNMAPPED_READ)
    else $error("read data not zero outside a read");

  lock_cov_c: cover property (wr_in && chan_hit[0] && lock_reg);
  write_cov_c: cover property (wr_in && chan_hit[1] && !lock_reg);
  high_cov_c: cover property (high_band_out[2]);
  read_cov_c: cover property (rd_in && chan_hit[0]);
  lock_set_cov_c: cover property (wr_in && lock_hit && wdata_in[`LOCK_BIT]);

endmodule : fan_span_config
`default_nettype wire

//--- verilog/fan_span_params.svh
// Register offsets, field positions and reset values for the fan-drive
// channel span/rate configuration block.
// Assumes an 8-bit register address space reached over a plain port.
`ifndef FAN_SPAN_PARAMS_SVH
`define FAN_SPAN_PARAMS_SVH
`define ADDR_W           8
`define DATA_W           8
`define CHAN_N           3
`define OFF_CHAN0        8'h5f
`define OFF_CHAN1        8'h60
`define OFF_CHAN2        8'h61
`define OFF_LOCK         8'h40
`define LOCK_BIT         0
`define RATE_LSB         0
`define RATE_MSB         2
`define BAND_BIT         3
`define SPAN_LSB         4
`define SPAN_MSB         7
`define RATE_RESET       3'h4
`define BAND_RESET       1'h0
`define SPAN_RESET       4'hc
`define CHAN_RESET       8'hc4
`define UNMAPPED_READ    8'h00
`endif

//--- verilog/fan_span_pkg.sv
// Types shared by the fan-drive channel configuration block.
// Assumes fan_span_params.svh is on the include path.
package fan_span_pkg;
  // Low-frequency rate codes, 000 through 111.
  typedef enum logic [2:0] {
    rate_11p0_hz = 3'b000,
    rate_14p7_hz = 3'b001,
    rate_22p1_hz = 3'b010,
    rate_29p4_hz = 3'b011,
    rate_35p3_hz = 3'b100,
    rate_44p1_hz = 3'b101,
    rate_58p8_hz = 3'b110,
    rate_88p2_hz = 3'b111
  } pulse_rate_select_t;

  // Per-channel settings as handed to the duty-cycle generator.
  typedef struct packed {
    logic [3:0]         temp_span;
    logic               drive_band_select;
    pulse_rate_select_t pulse_rate_select;
  } fan_drive_channel_t;
endpackage : fan_span_pkg
